/* rsw_defs.svh */
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

// Clock and time figures
`define RSW_CLK_NS      10
`define RSW_TOUT_NS     64000000
`define RSW_TOUT_CYC    ((`RSW_TOUT_NS + `RSW_CLK_NS - 1) / `RSW_CLK_NS)
`define RSW_BOD_NS      2000
`define RSW_BOD_CYC     ((`RSW_BOD_NS + `RSW_CLK_NS - 1) / `RSW_CLK_NS)
`define RSW_CE_CYC      3'h4

// Watchdog time-out select
`define RSW_WDT_BASE    21'h00_0800
`define RSW_WDP_MAX     4'h9

// Register byte offsets
`define RSW_OFS_CTRL    4'h0
`define RSW_OFS_STAT    4'h4
`define RSW_OFS_RESTART 4'h8

// Reset values
`define RSW_CTRL_RST    8'h00
`define RSW_STAT_RST    4'h1
`define RSW_SYNC_RST    6'h20

`endif

/* rsw_pkg.sv */
package rsw_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       irq_flag;
    logic       timeout_irq_enable;
    logic       wdp_hi;
    logic       change_enable_bit;
    logic       watchdog_enable_bit;
    logic [2:0] wdp_lo;
  } rsw_ctrl_t;

  // Reset cause flags, bit 3 down to bit 0
  typedef struct packed {
    logic watchdog_reset_flag;
    logic brownout_flag;
    logic external_flag;
    logic power_on_flag;
  } rsw_flags_t;

  typedef enum logic [2:0] {
    RSW_HOLD  = 3'b001,
    RSW_COUNT = 3'b010,
    RSW_RUN   = 3'b100
  } rsw_state_t;

endpackage : rsw_pkg

/* rsw_top.sv */
`timescale 1ns/1ps
`include "rsw_defs.svh"

module rsw_top #(
  parameter int unsigned TOUT_CYC = `RSW_TOUT_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Pins, detectors and fuses
  input  wire logic        ext_reset_n,
  input  wire logic        por_low,
  input  wire logic        bod_low,
  input  wire logic        wdt_osc,
  input  wire logic        always_on_fuse,
  input  wire logic        brownout_detector_en,
  // Core side
  input  wire logic        wdt_restart,
  input  wire logic        wdt_irq_ack,
  input  wire logic        comparator_bandgap_select,
  input  wire logic        adc_enable,
  // Outputs
  output logic             core_reset,
  output logic             wdt_reset_pulse,
  output logic             timeout_irq,
  output logic             bandgap_on
);

  // Input synchronisers; pin stage resets high so no false pin reset follows rst
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic       osc_d_r;
  logic       ext_n_s;
  logic       por_s;
  logic       bod_s;
  logic       osc_s;
  logic       lvl2;
  logic       bod_en_s;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= `RSW_SYNC_RST;
      sync2_r <= `RSW_SYNC_RST;
      osc_d_r <= 1'b0;
    end else begin
      sync1_r <= {ext_reset_n, por_low, bod_low, wdt_osc, always_on_fuse,
                  brownout_detector_en};
      sync2_r <= sync1_r;
      osc_d_r <= osc_s;
    end
  end

  assign ext_n_s  = sync2_r[5];
  assign por_s    = sync2_r[4];
  assign bod_s    = sync2_r[3];
  assign osc_s    = sync2_r[2];
  assign lvl2     = sync2_r[1];
  assign bod_en_s = sync2_r[0];

  // Bus slave: one wait cycle, answer on the second edge
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_restart;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go      = avs_write & ack_r & avs_byteenable[0];
  assign wr_ctrl    = wr_go & (avs_address == `RSW_OFS_CTRL);
  assign wr_stat    = wr_go & (avs_address == `RSW_OFS_STAT);
  assign wr_restart = wr_go & (avs_address == `RSW_OFS_RESTART);

  // Registers and state
  rsw_pkg::rsw_ctrl_t  ctrl_r;
  rsw_pkg::rsw_ctrl_t  ctrl_nxt;
  rsw_pkg::rsw_ctrl_t  wval;
  rsw_pkg::rsw_flags_t flags_r;
  rsw_pkg::rsw_flags_t flags_nxt;
  rsw_pkg::rsw_state_t state_r;
  rsw_pkg::rsw_state_t state_nxt;
  logic [2:0]          ce_cnt_r;
  logic [2:0]          ce_cnt_nxt;
  logic [19:0]         wdt_cnt_r;
  logic [19:0]         wdt_cnt_nxt;
  logic [15:0]         bod_cnt_r;
  logic [15:0]         bod_cnt_nxt;
  logic [31:0]         dly_r;
  logic [31:0]         dly_nxt;
  logic                pulse_r;
  logic                pulse_nxt;
  logic                bg_r;
  logic                bg_nxt;

  // Watchdog decode
  logic        chip_rst;
  logic        en_eff;
  logic        run;
  logic        tick;
  logic        restart;
  logic [3:0]  timeout_select_bits;
  logic [3:0]  sel;
  logic [20:0] lim;
  logic        hit;
  logic        timeout;
  logic        tmo_irq;
  logic        tmo_rst;
  logic        bod_hit;
  logic        src;

  assign wval     = rsw_pkg::rsw_ctrl_t'(avs_writedata[7:0]);
  assign chip_rst = (state_r != rsw_pkg::RSW_RUN);
  // Fuse or cause flag keep the watchdog armed
  assign en_eff   = lvl2 | ctrl_r.watchdog_enable_bit
                  | flags_r.watchdog_reset_flag;
  assign run      = en_eff | ctrl_r.timeout_irq_enable;
  assign tick     = osc_s & ~osc_d_r;
  assign restart  = wdt_restart | wr_restart;
  assign timeout_select_bits      = {ctrl_r.wdp_hi, ctrl_r.wdp_lo};
  assign sel      = (timeout_select_bits > `RSW_WDP_MAX) ? `RSW_WDP_MAX : timeout_select_bits;
  assign lim      = `RSW_WDT_BASE << sel;
  assign hit      = (wdt_cnt_r == 20'(lim - 21'h00_0001));
  assign timeout  = tick & hit & run & ~restart & ~chip_rst;
  assign tmo_irq  = timeout & ctrl_r.timeout_irq_enable;
  assign tmo_rst  = timeout & ~ctrl_r.timeout_irq_enable & en_eff;
  assign bod_hit  = (bod_cnt_r == 16'(`RSW_BOD_CYC));
  // Pulse is a source only while high, so counting starts as it falls
  assign src      = por_s | ~ext_n_s | bod_hit | pulse_r;

  // Control register next value
  always_comb begin
    ctrl_nxt   = ctrl_r;
    ce_cnt_nxt = ce_cnt_r;
    if (ce_cnt_r != 3'h0) begin
      ce_cnt_nxt = ce_cnt_r - 3'h1;
      if (ce_cnt_r == 3'h1) begin
        ctrl_nxt.change_enable_bit = 1'b0;
      end
    end
    if (wdt_irq_ack) begin
      ctrl_nxt.irq_flag = 1'b0;
    end
    if (wr_ctrl) begin
      if (wval.irq_flag) begin
        ctrl_nxt.irq_flag = 1'b0;
      end
      ctrl_nxt.timeout_irq_enable = wval.timeout_irq_enable;
      if (wval.change_enable_bit & wval.watchdog_enable_bit) begin
        ctrl_nxt.change_enable_bit = 1'b1;
        ce_cnt_nxt                 = `RSW_CE_CYC;
      end else begin
        ctrl_nxt.change_enable_bit = 1'b0;
        ce_cnt_nxt                 = 3'h0;
      end
      if (wval.watchdog_enable_bit) begin
        ctrl_nxt.watchdog_enable_bit = 1'b1;
      end else if (ctrl_r.change_enable_bit) begin
        ctrl_nxt.watchdog_enable_bit = 1'b0;
      end
      if (!lvl2 || ctrl_r.change_enable_bit) begin
        ctrl_nxt.wdp_hi = wval.wdp_hi;
        ctrl_nxt.wdp_lo = wval.wdp_lo;
      end
    end
    if (!lvl2 && flags_r.watchdog_reset_flag) begin
      ctrl_nxt.watchdog_enable_bit = 1'b1;
    end
    // Time-out event wins over a clear in the same cycle
    if (tmo_irq) begin
      ctrl_nxt.irq_flag = 1'b1;
      if (en_eff) begin
        ctrl_nxt.timeout_irq_enable = 1'b0;
      end
    end
    if (chip_rst) begin
      ctrl_nxt   = `RSW_CTRL_RST;
      ce_cnt_nxt = 3'h0;
    end
  end

  // Reset cause flags, write zero clears, set wins
  always_comb begin
    flags_nxt = flags_r;
    if (wr_stat) begin
      flags_nxt = flags_r & rsw_pkg::rsw_flags_t'(avs_writedata[3:0]);
    end
    if (pulse_r) begin
      flags_nxt.watchdog_reset_flag = 1'b1;
    end
    if (bod_hit) begin
      flags_nxt.brownout_flag = 1'b1;
    end
    if (!ext_n_s) begin
      flags_nxt.external_flag = 1'b1;
    end
    if (por_s) begin
      flags_nxt = `RSW_STAT_RST;
    end
  end

  // Watchdog counter and brown-out filter
  always_comb begin
    wdt_cnt_nxt = wdt_cnt_r;
    pulse_nxt   = tmo_rst;
    if (chip_rst || !run || restart) begin
      wdt_cnt_nxt = 20'h0_0000;
    end else if (tick) begin
      wdt_cnt_nxt = hit ? 20'h0_0000 : wdt_cnt_r + 20'h0_0001;
    end
    bod_cnt_nxt = bod_cnt_r;
    if (!(bod_s && bod_en_s)) begin
      bod_cnt_nxt = 16'h0000;
    end else if (!bod_hit) begin
      bod_cnt_nxt = bod_cnt_r + 16'h0001;
    end
    bg_nxt = bod_en_s | comparator_bandgap_select | adc_enable;
  end

  // Reset stretcher
  always_comb begin
    state_nxt = state_r;
    dly_nxt   = dly_r;
    case (state_r)
      rsw_pkg::RSW_HOLD: begin
        dly_nxt = 32'h0000_0000;
        if (!src) begin
          state_nxt = rsw_pkg::RSW_COUNT;
        end
      end
      rsw_pkg::RSW_COUNT: begin
        if (src) begin
          state_nxt = rsw_pkg::RSW_HOLD;
        end else if (dly_r >= 32'(TOUT_CYC - 1)) begin
          state_nxt = rsw_pkg::RSW_RUN;
        end else begin
          dly_nxt = dly_r + 32'h0000_0001;
        end
      end
      rsw_pkg::RSW_RUN: begin
        if (src) begin
          state_nxt = rsw_pkg::RSW_HOLD;
        end
      end
      default: begin
        state_nxt = rsw_pkg::RSW_HOLD;
      end
    endcase
  end

  // Bus next values
  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      case (avs_address)
        `RSW_OFS_CTRL: begin
          rdata_nxt = {24'h00_0000, ctrl_r.irq_flag, ctrl_r.timeout_irq_enable,
                       ctrl_r.wdp_hi, ctrl_r.change_enable_bit, en_eff,
                       ctrl_r.wdp_lo};
        end
        `RSW_OFS_STAT: begin
          rdata_nxt = {28'h000_0000, flags_r};
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r     <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      ctrl_r    <= `RSW_CTRL_RST;
      ce_cnt_r  <= 3'h0;
      flags_r   <= `RSW_STAT_RST;
      wdt_cnt_r <= 20'h0_0000;
      bod_cnt_r <= 16'h0000;
      pulse_r   <= 1'b0;
      bg_r      <= 1'b0;
      state_r   <= rsw_pkg::RSW_HOLD;
      dly_r     <= 32'h0000_0000;
    end else begin
      ack_r     <= ack_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      ce_cnt_r  <= ce_cnt_nxt;
      flags_r   <= flags_nxt;
      wdt_cnt_r <= wdt_cnt_nxt;
      bod_cnt_r <= bod_cnt_nxt;
      pulse_r   <= pulse_nxt;
      bg_r      <= bg_nxt;
      state_r   <= state_nxt;
      dly_r     <= dly_nxt;
    end
  end

  // Raw pin and power-on detector paths bypass the clock so reset works with no clock; brown-out goes through the clocked filter;
  // pulse-width filtering of the pin is left to its analog front end
  assign core_reset      = chip_rst | por_low | ~ext_reset_n;
  assign wdt_reset_pulse = pulse_r;
  assign timeout_irq     = ctrl_r.irq_flag & ctrl_r.timeout_irq_enable;
  assign bandgap_on      = bg_r;
  assign avs_readdata    = rdata_r;

endmodule : rsw_top

/* rsw_top_checker.sv */
`timescale 1ns/1ps
module rsw_top_checker #(
  parameter int unsigned TOUT_CYC = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Sources and core side
  input wire logic ext_reset_n,
  input wire logic por_low,
  input wire logic bod_low,
  input wire logic wdt_restart,
  input wire logic comparator_bandgap_select,
  input wire logic adc_enable,
  // Outputs
  input wire logic core_reset,
  input wire logic wdt_reset_pulse,
  input wire logic timeout_irq,
  input wire logic bandgap_on
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;

  // Cycles of held reset with pin and detector already released
  always_comb cnt_nxt = (core_reset && !por_low && ext_reset_n) ? cnt_r + 32'h0000_0001 : '0;
  always_ff @(posedge core_clk) cnt_r <= rst ? '0 : cnt_nxt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_pulse_width: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("watchdog pulse longer than one cycle");
  chk_pulse_holds: assert property (wdt_reset_pulse |=> core_reset [*3])
    else $error("watchdog pulse did not start the delay");
  chk_por_direct: assert property (por_low |-> core_reset)
    else $error("power-on low without reset");
  chk_pin_direct: assert property (!ext_reset_n |-> core_reset)
    else $error("pin low without reset");
  chk_bandgap_src: assert property ((comparator_bandgap_select || adc_enable)
    |=> bandgap_on)
    else $error("bandgap off while requested");
  chk_release_late: assert property ($fell(core_reset) |-> cnt_r >= TOUT_CYC)
    else $error("reset released before start-up period");
  chk_restart_quiet: assert property (wdt_restart |=> !wdt_reset_pulse [*8])
    else $error("time-out right after restart");
  chk_irq_not_reset: assert property ($rose(timeout_irq) |-> !wdt_reset_pulse && !core_reset)
    else $error("interrupt time-out also reset");
  chk_pulse_in_run: assert property (wdt_reset_pulse |-> !$past(core_reset))
    else $error("watchdog fired during chip reset");
  chk_reset_cause: assert property ($rose(core_reset) |->
    por_low || !ext_reset_n || bod_low || $past(wdt_reset_pulse))
    else $error("reset without a source");
endmodule : rsw_top_checker

bind rsw_top rsw_top_checker #(.TOUT_CYC(TOUT_CYC)) u_chk (.*);

/* rsw_top_tb.sv */
`timescale 1ns/1ps
module rsw_top_tb;
  localparam int unsigned TC = 20;
  logic        core_clk, rst, avs_read, avs_write, avs_waitrequest, ext_reset_n;
  logic        por_low, bod_low, wdt_osc, always_on_fuse, brownout_detector_en;
  logic        wdt_restart, wdt_irq_ack, comparator_bandgap_select, adc_enable;
  logic        core_reset, wdt_reset_pulse, timeout_irq, bandgap_on;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0]  div_r;
  int          n_errors, n_checks, n, n_pulse;

  rsw_top #(.TOUT_CYC(TC)) DUT (.*);

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  // Fast stand-in oscillator: real rate would need millions of cycles a time-out
  always @(posedge core_clk) begin
    div_r <= div_r + 2'h1;
    wdt_osc <= div_r[1];
  end

  always @(negedge core_clk) n_pulse += (wdt_reset_pulse === 1'b1);

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // 0 reset released, 1 watchdog pulse, 2 interrupt
  task automatic wait_on(input int s, input int lim);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!(s == 0 ? core_reset === 1'b0 : s == 1 ? wdt_reset_pulse === 1'b1
                 : timeout_irq === 1'b1) && n < lim);
    if (n >= lim) begin
      chk("wait done", 1, 0);
      final_report();
    end
  endtask : wait_on

  // Request held until a rising edge samples waitrequest low; rel=0 keeps the bus busy
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic rel);
    int k;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    if (k >= 50) begin
      chk("bus answer", 1, 0);
      final_report();
    end
    if (rel) begin
      avs_read <= 0;
      avs_write <= 0;
      @(posedge core_clk);
    end
  endtask : bus

  task automatic cw(input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] e);
    if (d1 != 8'h00) bus(1'b1, 4'h0, d1, 1'b0);
    bus(1'b1, 4'h0, d2, 1'b1);
    bus(1'b0, 4'h0, 8'h00, 1'b1);
    chk("ctrl", {24'h00_0000, e}, q);
  endtask : cw

  task automatic src(input logic [2:0] s, input int hold, input logic [7:0] e);
    {bod_low, ext_reset_n, por_low} <= s ^ 3'b010;
    repeat (hold) @(posedge core_clk);
    @(negedge core_clk);
    chk("source reset", 1'b1, core_reset);
    @(posedge core_clk);
    {bod_low, ext_reset_n, por_low} <= 3'b010;
    wait_on(0, 200);
    chk("stretch", 1'b1, n >= TC);
    @(posedge core_clk);
    bus(1'b0, 4'h4, 8'h00, 1'b1);
    chk("reset flags", {24'h00_0000, e}, q);
  endtask : src

  initial begin
    void'($urandom(32'hd796_e596));
    {rst, ext_reset_n, avs_byteenable} = 6'h31;
    {avs_read, avs_write, por_low, bod_low, always_on_fuse, brownout_detector_en} = '0;
    {wdt_restart, wdt_irq_ack, comparator_bandgap_select, adc_enable, div_r, wdt_osc} = '0;
    {avs_address, avs_writedata, n_errors, n_checks, n_pulse} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 0;
    wait_on(0, 200);
    chk("start stretch", 1'b1, n >= TC);
    @(posedge core_clk);
    cw(8'h00, 8'h00, 8'h00);
    bus(1'b1, 4'hC, 8'hFF, 1'b1);
    bus(1'b0, 4'hC, 8'h00, 1'b1);
    chk("unmapped", 32'h0000_0000, q);
    for (int i = 0; i < 8; i++) begin
      {brownout_detector_en, comparator_bandgap_select, adc_enable} <= 3'(i);
      repeat (5) @(negedge core_clk);
      chk("bandgap", i != 0, bandgap_on);
      @(posedge core_clk);
    end
    {brownout_detector_en, comparator_bandgap_select, adc_enable} <= 3'b000;
    cw(8'h00, 8'h08, 8'h08);
    bus(1'b1, 4'h0, 8'h18, 1'b1);
    repeat (6) @(posedge core_clk);
    cw(8'h00, 8'h00, 8'h08);
    cw(8'h18, 8'h00, 8'h00);
    cw(8'h00, 8'h40, 8'h40);
    wait_on(2, 9000);
    chk("irq no reset", 2'b00, {wdt_reset_pulse, core_reset});
    @(posedge core_clk);
    wdt_irq_ack <= 1;
    @(posedge core_clk);
    wdt_irq_ack <= 0;
    @(negedge core_clk);
    chk("irq ack", 1'b0, timeout_irq);
    @(posedge core_clk);
    cw(8'h00, 8'h80, 8'h00);
    cw(8'h00, 8'h08, 8'h08);
    repeat (4) begin
      repeat (500 + $urandom % 6000) @(posedge core_clk);
      wdt_restart <= 1;
      @(posedge core_clk);
      wdt_restart <= 0;
    end
    chk("restart", 0, n_pulse);
    wait_on(1, 9000);
    chk("period", 1'b1, n >= 8180 && n <= 8204);
    @(negedge core_clk);
    chk("pulse", 2'b01, {wdt_reset_pulse, core_reset});
    wait_on(0, 200);
    chk("wdt stretch", 1'b1, n >= TC);
    @(posedge core_clk);
    bus(1'b0, 4'h4, 8'h00, 1'b1);
    chk("wdt flag", 32'h0000_0009, q);
    cw(8'h18, 8'h00, 8'h08);
    bus(1'b1, 4'h4, 8'h00, 1'b1);
    cw(8'h18, 8'h00, 8'h00);
    src(3'b010, 4, 8'h02);
    src(3'b001, 4, 8'h01);
    brownout_detector_en <= 1;
    bod_low <= 1;
    repeat (50) @(posedge core_clk);
    bod_low <= 0;
    @(negedge core_clk);
    chk("short dip", 1'b0, core_reset);
    @(posedge core_clk);
    src(3'b100, 250, 8'h05);
    always_on_fuse <= 1;
    repeat (4) @(posedge core_clk);
    cw(8'h00, 8'h00, 8'h08);
    cw(8'h18, 8'h01, 8'h09);
    cw(8'h00, 8'h02, 8'h09);
    final_report();
  end
endmodule : rsw_top_tb
